// ===== src/dbg_regs.svh
// Register offsets, field positions and reset values of the debug enable block
`ifndef DBG_REGS_SVH
`define DBG_REGS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define VEC_WIDTH 128
`define ADDR_WIDTH 5
`define WORD_WIDTH 32

// ----------------------------------------------------------------
// Register byte offsets on the Avalon-MM slave
// ----------------------------------------------------------------
`define OFS_STATE_VALUE 5'h00
`define OFS_CONTROL 5'h04
`define OFS_IRQ_STATUS 5'h08
`define OFS_IRQ_MASK 5'h0C
`define OFS_ENABLE_W0 5'h10
`define OFS_ENABLE_W3 5'h1C

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define CTRL_PROV_ENABLE_BIT 0
`define IRQ_VALID_BIT 0
`define IRQ_FATAL_BIT 1
`define IRQ_WIDTH 2
`define STATE_FIELD_WIDTH 2

// ----------------------------------------------------------------
// One-time-programmable state word codes
// ----------------------------------------------------------------
`define OTP_CODE_CHIP_MAKER 32'h0000_0000
`define OTP_CODE_DEVICE_MAKER 32'h0000_0001
`define OTP_CODE_SECURE 32'h0000_0003
`define OTP_CODE_RETURN 32'h0000_0007

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define VEC_ONES {128{1'b1}}
`define VEC_ZERO {128{1'b0}}
// Index is {mode, state}; secure enabled in the first mode is clear
`define DEFAULT_VECTORS_RESET \
	{{5{`VEC_ONES}}, `VEC_ZERO, {2{`VEC_ONES}}}
`define PERMANENT_MASKS_RESET {8{`VEC_ONES}}
`define PROV_MASK_RESET {128{1'b1}}
`define CONTROL_RESET 32'h0000_0000
`define IRQ_MASK_RESET 2'h0

`endif

// ===== src/dbg_pkg.sv
// Types shared by both ends of the debug enable link
package dbg_pkg;

	// ----------------------------------------------------------------
	// Lifecycle states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CHIP_MAKER_STATE = 2'h0,
		DEVICE_MAKER_STATE = 2'h1,
		SECURE_ENABLED_STATE = 2'h2,
		RETURN_STATE = 2'h3
	} lifecycle_state_e;

	// ----------------------------------------------------------------
	// Boot sequence of the device end
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		WAIT_OTP = 3'b001,
		RUNNING = 3'b010,
		FAULT = 3'b100
	} boot_state_e;

endpackage : dbg_pkg

// ===== src/debug_link_if.sv
// Link between the debug control unit and the system that consumes it
`timescale 1ns/100ps
`default_nettype none

interface debug_link_if (
	input wire logic clock
);
	dbg_pkg::lifecycle_state_e lifecycle_state;
	logic lifecycle_state_valid;
	logic fatal_error;
	logic provisioning_reset_request;
	logic [127:0] debug_control;
	logic [127:0] provisioning_debug_mask;
	logic [31:0] otp_word;
	logic otp_word_valid;

	modport device (
		output lifecycle_state,
		output lifecycle_state_valid,
		output fatal_error,
		output provisioning_reset_request,
		output debug_control,
		input provisioning_debug_mask,
		input otp_word,
		input otp_word_valid
	);

	modport system (
		input lifecycle_state,
		input lifecycle_state_valid,
		input fatal_error,
		input provisioning_reset_request,
		input debug_control,
		output provisioning_debug_mask,
		output otp_word,
		output otp_word_valid
	);
endinterface : debug_link_if

`default_nettype wire

// ===== src/pin_sync.sv
// Three-stage synchroniser for pin inputs; a change counts once stages agree
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level
);
	logic [WIDTH-1:0] s1_q, s2_q, s3_q, level_q;
	logic [WIDTH-1:0] level_d;

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("pin_sync width must be at least one");
		end
	endgenerate

	always_comb begin
		level_d = level_q;
		if (s2_q == s3_q) begin
			level_d = s3_q;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			level_q <= '0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			level_q <= level_d;
		end
	end

	assign level = level_q;
endmodule : pin_sync

`default_nettype wire

// ===== src/debug_control_unit.sv
// Device end: lifecycle state, debug enable vector and register slave
//
// Overview of operation
// - Load enable vector by state and mode
// - Defaults all ones, secure/first mode clear
// - Permanent mask per state/mode clears outputs
// - State register read stalls until valid
// - Invalid state raises fatal error, not valid
// - Integrator may route fatal error to reset
// - Consumers ignore state while not valid
// - Provisioning reset hits cores, DMA, keys
// - One memory region survives provisioning reset
// - Blank one-time memory reads as zero
// - Integrator sets provisioning mask bits
// - Outputs report state and debug domains
// - All signals on the single core clock
// - Provisioning mask clears outputs while enabled
// - Report secure enabled until state known
//
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "dbg_regs.svh"

module debug_control_unit #(
	parameter int VEC_W = `VEC_WIDTH,
	parameter logic [7:0][127:0] DEFAULT_VECTORS = `DEFAULT_VECTORS_RESET,
	parameter logic [7:0][127:0] PERMANENT_MASKS = `PERMANENT_MASKS_RESET
) (
	input wire logic clock,
	input wire logic reset,
	debug_link_if.device link,
	input wire logic test_port_mode_select,
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic irq
);
	import dbg_pkg::*;

	generate
		if (VEC_W != 128) begin : g_bad_width
			$error("debug enable vector must be 128 bits");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Test-port mode pin
	// ----------------------------------------------------------------
	logic mode_level;

	pin_sync #(
		.WIDTH(1)
	) i_pin_sync (
		.clock(clock),
		.reset(reset),
		.pin(test_port_mode_select),
		.level(mode_level)
	);

	// ----------------------------------------------------------------
	// Boot sequence and state decode
	// ----------------------------------------------------------------
	boot_state_e boot_q, boot_d;
	lifecycle_state_e state_q, state_d;
	logic [127:0] enable_q, enable_d;
	lifecycle_state_e decoded;
	logic decode_ok;
	logic [2:0] vec_idx;
	logic valid_event, fatal_event;
	logic wr_take;
	logic [2:0] wr_word;

	always_comb begin
		decode_ok = 1'b1;
		decoded = SECURE_ENABLED_STATE;
		case (link.otp_word)
			`OTP_CODE_CHIP_MAKER: decoded = CHIP_MAKER_STATE;
			`OTP_CODE_DEVICE_MAKER: decoded = DEVICE_MAKER_STATE;
			`OTP_CODE_SECURE: decoded = SECURE_ENABLED_STATE;
			`OTP_CODE_RETURN: decoded = RETURN_STATE;
			default: decode_ok = 1'b0;
		endcase
	end

	assign vec_idx = {mode_level, decoded};
	assign wr_word = 3'(address[4:2] - 3'h4);

	always_comb begin
		boot_d = boot_q;
		state_d = state_q;
		enable_d = enable_q;
		valid_event = 1'b0;
		fatal_event = 1'b0;
		case (boot_q)
			WAIT_OTP: begin
				if (link.otp_word_valid && decode_ok) begin
					boot_d = RUNNING;
					state_d = decoded;
					enable_d = DEFAULT_VECTORS[vec_idx];
					valid_event = 1'b1;
				end else if (link.otp_word_valid) begin
					boot_d = FAULT;
					fatal_event = 1'b1;
				end
			end
			RUNNING: begin
				if (wr_take && address >= `OFS_ENABLE_W0) begin
					enable_d[wr_word[1:0]*32 +: 32] = writedata;
				end
			end
			FAULT: begin
				boot_d = FAULT;
			end
			default: begin
				boot_d = WAIT_OTP;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			boot_q <= WAIT_OTP;
			state_q <= SECURE_ENABLED_STATE;
			enable_q <= '0;
		end else begin
			boot_q <= boot_d;
			state_q <= state_d;
			enable_q <= enable_d;
		end
	end

	// ----------------------------------------------------------------
	// Link outputs
	// ----------------------------------------------------------------
	logic [127:0] control_q, control_d;
	logic prov_en_q, prov_en_d;
	logic [2:0] mask_idx;

	assign mask_idx = {mode_level, state_q};

	always_comb begin
		control_d = enable_q & PERMANENT_MASKS[mask_idx];
		if (prov_en_q) begin
			control_d = control_d & link.provisioning_debug_mask;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			control_q <= '0;
		end else begin
			control_q <= control_d;
		end
	end

	// Outputs report state, validity and domains
	assign link.debug_control = control_q;
	assign link.lifecycle_state = state_q;
	assign link.lifecycle_state_valid = boot_q == RUNNING;
	assign link.fatal_error = boot_q == FAULT;
	assign link.provisioning_reset_request = prov_en_q;

	// ----------------------------------------------------------------
	// Avalon-MM slave, one wait cycle per access; state reads wait longer until valid
	// ----------------------------------------------------------------
	logic ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic stall;
	logic [1:0] irq_status_q, irq_status_d;
	logic [1:0] irq_mask_q, irq_mask_d;
	logic status_clear;
	localparam logic [31:0] CONTROL_INIT = `CONTROL_RESET;

	// State reads hold off until the state is valid
	assign stall = read && address == `OFS_STATE_VALUE && boot_q != RUNNING;
	assign wr_take = ack_q && write;

	always_comb begin
		ack_d = (read || write) && !ack_q && !stall;
		rdata_d = rdata_q;
		status_clear = 1'b0;
		if (ack_d && read) begin
			rdata_d = '0;
			case (address)
				`OFS_STATE_VALUE: rdata_d = {30'h0, state_q};
				`OFS_CONTROL: rdata_d = {31'h0, prov_en_q};
				`OFS_IRQ_STATUS: begin
					rdata_d = {30'h0, irq_status_q};
					status_clear = 1'b1;
				end
				`OFS_IRQ_MASK: rdata_d = {30'h0, irq_mask_q};
				default: begin
					if (address >= `OFS_ENABLE_W0) begin
						rdata_d = enable_q[wr_word[1:0]*32 +: 32];
					end
				end
			endcase
		end
	end

	always_comb begin
		prov_en_d = prov_en_q;
		irq_mask_d = irq_mask_q;
		if (wr_take && address == `OFS_CONTROL) begin
			prov_en_d = writedata[`CTRL_PROV_ENABLE_BIT];
		end
		if (wr_take && address == `OFS_IRQ_MASK) begin
			irq_mask_d = writedata[1:0];
		end
		irq_status_d = status_clear ? 2'h0 : irq_status_q;
		irq_status_d[`IRQ_VALID_BIT] = irq_status_d[`IRQ_VALID_BIT]
			| valid_event;
		irq_status_d[`IRQ_FATAL_BIT] = irq_status_d[`IRQ_FATAL_BIT]
			| fatal_event;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			ack_q <= 1'b0;
			rdata_q <= '0;
			prov_en_q <= CONTROL_INIT[`CTRL_PROV_ENABLE_BIT];
			irq_status_q <= 2'h0;
			irq_mask_q <= `IRQ_MASK_RESET;
		end else begin
			ack_q <= ack_d;
			rdata_q <= rdata_d;
			prov_en_q <= prov_en_d;
			irq_status_q <= irq_status_d;
			irq_mask_q <= irq_mask_d;
		end
	end

	assign waitrequest = !ack_q;
	assign readdata = rdata_q;
	assign irq = |(irq_status_q & irq_mask_q);
endmodule : debug_control_unit

`default_nettype wire

// ===== src/debug_system_end.sv
// System end: feeds the state word, consumes state and debug controls
`timescale 1ns/100ps
`default_nettype none
`include "dbg_regs.svh"

module debug_system_end #(
	parameter bit ERASED_READS_ONE = 1'b0,
	parameter bit FATAL_RESETS = 1'b1,
	parameter logic [127:0] PROV_MASK = `PROV_MASK_RESET
) (
	input wire logic clock,
	input wire logic reset,
	debug_link_if.system link,
	input wire logic [31:0] otp_raw,
	input wire logic otp_raw_valid,
	output logic [1:0] consumer_state,
	output logic consumer_state_valid,
	output logic [127:0] debug_domain_enable,
	output logic system_reset_request,
	output logic processor_reset,
	output logic dma_reset,
	output logic key_manager_reset,
	output logic memory_reset,
	output logic retained_region_hold
);
	import dbg_pkg::*;

	// ----------------------------------------------------------------
	// State word into the device
	// ----------------------------------------------------------------
	logic [31:0] otp_q, otp_d;
	logic otp_valid_q;

	always_comb begin
		otp_d = ERASED_READS_ONE ? ~otp_raw : otp_raw;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			otp_q <= '0;
			otp_valid_q <= 1'b0;
		end else begin
			otp_q <= otp_d;
			otp_valid_q <= otp_raw_valid;
		end
	end

	assign link.otp_word = otp_q;
	assign link.otp_word_valid = otp_valid_q;
	assign link.provisioning_debug_mask = PROV_MASK;

	// ----------------------------------------------------------------
	// Consumers of state, debug controls and resets
	// ----------------------------------------------------------------
	logic [1:0] cstate_q, cstate_d;
	logic cvalid_q, cvalid_d;
	logic [127:0] dom_q;
	logic sys_rst_q, sys_rst_d;
	logic prov_rst_q;

	always_comb begin
		cvalid_d = link.lifecycle_state_valid;
		cstate_d = cstate_q;
		if (link.lifecycle_state_valid) begin
			cstate_d = link.lifecycle_state;
		end
		sys_rst_d = FATAL_RESETS && link.fatal_error;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			cstate_q <= SECURE_ENABLED_STATE;
			cvalid_q <= 1'b0;
			dom_q <= '0;
			sys_rst_q <= 1'b0;
			prov_rst_q <= 1'b0;
		end else begin
			cstate_q <= cstate_d;
			cvalid_q <= cvalid_d;
			dom_q <= link.debug_control;
			sys_rst_q <= sys_rst_d;
			prov_rst_q <= link.provisioning_reset_request;
		end
	end

	assign consumer_state = cstate_q;
	assign consumer_state_valid = cvalid_q;
	assign debug_domain_enable = dom_q;
	assign system_reset_request = sys_rst_q;
	assign processor_reset = prov_rst_q;
	assign dma_reset = prov_rst_q;
	assign key_manager_reset = prov_rst_q;
	assign memory_reset = 1'b0;
	assign retained_region_hold = 1'b1;
endmodule : debug_system_end

`default_nettype wire

// ===== verification/debug_link_chk.sv
// Concurrent checks on the link between both ends
`timescale 1ns/100ps
`default_nettype none

module debug_link_chk (
	input wire logic clock,
	input wire logic reset,
	input wire logic [1:0] lifecycle_state,
	input wire logic lifecycle_state_valid,
	input wire logic fatal_error,
	input wire logic provisioning_reset_request,
	input wire logic [127:0] debug_control,
	input wire logic [127:0] provisioning_debug_mask,
	input wire logic [31:0] otp_word,
	input wire logic otp_word_valid
);
	import dbg_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	// ----------------------------------------------------------------
	// Boot outcome
	// ----------------------------------------------------------------
	property p_boot_answer;
		otp_word_valid && !lifecycle_state_valid && !fatal_error
			|=> lifecycle_state_valid || fatal_error;
	endproperty
	a_boot_answer: assert property (p_boot_answer)
		else $error("no answer one cycle after state word");
	property p_exclusive;
		!(lifecycle_state_valid && fatal_error);
	endproperty
	a_exclusive: assert property (p_exclusive)
		else $error("valid and fatal high together");
	property p_valid_hold;
		lifecycle_state_valid |=> lifecycle_state_valid;
	endproperty
	a_valid_hold: assert property (p_valid_hold)
		else $error("valid dropped without reset");
	property p_fatal_hold;
		fatal_error |=> fatal_error;
	endproperty
	a_fatal_hold: assert property (p_fatal_hold)
		else $error("fatal dropped without reset");
	property p_valid_cause;
		$rose(lifecycle_state_valid) |-> $past(otp_word_valid);
	endproperty
	a_valid_cause: assert property (p_valid_cause)
		else $error("valid rose without a state word");

	// ----------------------------------------------------------------
	// State and debug outputs
	// ----------------------------------------------------------------
	property p_secure_default;
		!lifecycle_state_valid && !fatal_error
			|-> lifecycle_state == SECURE_ENABLED_STATE;
	endproperty
	a_secure_default: assert property (p_secure_default)
		else $error("state not secure enabled before valid");
	property p_closed_until_valid;
		!lifecycle_state_valid |-> debug_control == '0;
	endproperty
	a_closed_until_valid: assert property (p_closed_until_valid)
		else $error("debug control open before valid");
	property p_prov_mask;
		provisioning_reset_request
			|=> (debug_control & ~provisioning_debug_mask) == '0;
	endproperty
	a_prov_mask: assert property (p_prov_mask)
		else $error("masked debug control high while provisioning");
	property p_state_stable;
		lifecycle_state_valid && $past(lifecycle_state_valid)
			|-> $stable(lifecycle_state);
	endproperty
	a_state_stable: assert property (p_state_stable)
		else $error("state changed while valid");

	c_valid: cover property ($rose(lifecycle_state_valid));
	c_fatal: cover property ($rose(fatal_error));
	c_prov: cover property ($rose(provisioning_reset_request));
endmodule : debug_link_chk

`default_nettype wire

// ===== verification/debug_enable_defaults_tb.sv
// Testbench for both ends of the debug enable link
`timescale 1ns/100ps
`default_nettype none
`include "dbg_regs.svh"

module debug_enable_defaults_tb;
	function automatic logic [7:0][127:0] pm_f();
		logic [7:0][127:0] v;
		for (int i = 0; i < 8; i++) v[i] = ~(128'h1 << i);
		return v;
	endfunction : pm_f
	localparam logic [7:0][127:0] PM = pm_f();
	localparam logic [127:0] PROV = ~128'hF0;

	logic clock, reset, mode, read, write, irq, waitrequest, otp_raw_valid;
	logic [4:0] address;
	logic [31:0] writedata, readdata, otp_raw, q;
	logic [1:0] c_state;
	logic c_valid, sys_rst, p_rst, d_rst, k_rst, m_rst, hold;
	logic [127:0] dom_en, ev;
	int err_count = 0;
	int n_compared = 0;
	int n;
	logic [31:0] codes [4] = '{`OTP_CODE_CHIP_MAKER, `OTP_CODE_DEVICE_MAKER,
		`OTP_CODE_SECURE, `OTP_CODE_RETURN};

	debug_link_if i_debug_link_if (.clock(clock));
	debug_control_unit #(.PERMANENT_MASKS(PM)) i_debug_control_unit (
		.clock(clock), .reset(reset), .link(i_debug_link_if),
		.test_port_mode_select(mode), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .irq(irq));
	debug_system_end #(.PROV_MASK(PROV)) i_debug_system_end (
		.clock(clock), .reset(reset), .link(i_debug_link_if),
		.otp_raw(otp_raw), .otp_raw_valid(otp_raw_valid),
		.consumer_state(c_state), .consumer_state_valid(c_valid),
		.debug_domain_enable(dom_en), .system_reset_request(sys_rst),
		.processor_reset(p_rst), .dma_reset(d_rst),
		.key_manager_reset(k_rst), .memory_reset(m_rst),
		.retained_region_hold(hold));
	debug_link_chk chk_link (
		.clock(clock), .reset(reset),
		.lifecycle_state(i_debug_link_if.lifecycle_state),
		.lifecycle_state_valid(i_debug_link_if.lifecycle_state_valid),
		.fatal_error(i_debug_link_if.fatal_error),
		.provisioning_reset_request(
			i_debug_link_if.provisioning_reset_request),
		.debug_control(i_debug_link_if.debug_control),
		.provisioning_debug_mask(i_debug_link_if.provisioning_debug_mask),
		.otp_word(i_debug_link_if.otp_word),
		.otp_word_valid(i_debug_link_if.otp_word_valid));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [127:0] s, e);
		n_compared++;
		if (s !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, e, s);
		end
	endtask : chk

	// Holds the request until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] r, output int cnt);
		@(posedge clock);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= d;
		cnt = 0;
		do begin
			@(posedge clock);
			cnt++;
		end while (waitrequest !== 1'b0);
		r = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus

	// Reset, then a state read that waits on the state word
	task automatic boot(input logic [31:0] code, input logic m);
		reset <= 1'b1;
		otp_raw_valid <= 1'b0;
		mode <= m;
		otp_raw <= code;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		// An undecodable word never answers, so that read stays held
		fork
			bus(1'b0, `OFS_STATE_VALUE, 32'h0, q, n);
			begin
				repeat (8) @(posedge clock);
				otp_raw_valid <= 1'b1;
				repeat (30) @(posedge clock);
			end
		join_any
		disable fork;
		repeat (3) @(posedge clock);
	endtask : boot

	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test

	// ----------------------------------------------------------------
	// Clock, watchdog and sequence
	// ----------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	initial begin
		repeat (3000) @(posedge clock);
		err_count++;
		stop_test();
	end

	initial begin
		{reset, mode, read, write, otp_raw_valid} <= 5'h10;
		{address, writedata, otp_raw} <= '0;
		for (int m = 0; m < 2; m++) begin
			for (int k = 0; k < 4; k++) begin
				boot(codes[k], m[0]);
				ev = (k == 2 && m == 0) ? '0 : '1;
				ev = ev & ~(128'h1 << (m * 4 + k));
				chk("stall", n > 8 && n < 40, 1'b1);
				chk("state read", q[1:0], k[1:0]);
				chk("debug control", i_debug_link_if.debug_control, ev);
				chk("domains", dom_en, ev);
				chk("consumer", {c_valid, c_state}, {1'b1, k[1:0]});
			end
		end
		bus(1'b1, `OFS_IRQ_MASK, 32'h3, q, n);
		@(posedge clock);
		chk("irq set", irq, 1'b1);
		bus(1'b0, `OFS_IRQ_STATUS, 32'h0, q, n);
		chk("status", q, 32'h1);
		bus(1'b0, `OFS_IRQ_STATUS, 32'h0, q, n);
		chk("status cleared", {irq, q}, 33'h0);
		bus(1'b0, 5'h02, 32'h0, q, n);
		chk("unaligned", q, 32'h0);
		bus(1'b1, `OFS_ENABLE_W0, 32'h0000_00FF, q, n);
		bus(1'b0, `OFS_ENABLE_W0, 32'h0, q, n);
		chk("enable word", q, 32'h0000_00FF);
		bus(1'b1, `OFS_CONTROL, 32'h1, q, n);
		repeat (4) @(posedge clock);
		// Word 0 now holds 0xFF; the other words keep their default
		ev = ev & PROV & ~128'hFFFF_FF00;
		chk("prov mask", i_debug_link_if.debug_control, ev);
		chk("prov reset", {p_rst, d_rst, k_rst, m_rst}, 4'hE);
		chk("retained", hold, 1'b1);
		boot(32'h0000_0002, 1'b0);
		chk("hang", {read, waitrequest}, 2'h3);
		chk("fatal", {i_debug_link_if.fatal_error,
			i_debug_link_if.lifecycle_state_valid}, 2'h2);
		chk("system reset", sys_rst, 1'b1);
		stop_test();
	end
endmodule : debug_enable_defaults_tb

`default_nettype wire
